/* File: common/dasm_map.svh */
`ifndef DASM_MAP_SVH
`define DASM_MAP_SVH
// ----------------------------------------
// Address field layout
// ----------------------------------------
`define DASM_ROW_BITS 13
`define DASM_ADDR_BITS 13
`define DASM_AUTOPRE_BIT 10
`define DASM_COL11_BIT 11
`define DASM_PAGE_BYTES 1024
// ----------------------------------------
// Extended mode register one bits
// ----------------------------------------
`define DASM_EMR_RSTROBE_BIT 11
`define DASM_EMR1_SEL 2'h1
// ----------------------------------------
// Data width codes
// ----------------------------------------
`define DASM_W4 2'h0
`define DASM_W8 2'h1
`define DASM_W16 2'h2
`endif

/* File: common/dasm_pkg.sv */
package dasm_pkg;
	typedef enum logic [3:0]
	{
		DASM_CMD_NOP = 4'h0,
		DASM_CMD_MRS = 4'h1,
		DASM_CMD_ACT = 4'h2,
		DASM_CMD_RD = 4'h3,
		DASM_CMD_WR = 4'h4,
		DASM_CMD_PRE = 4'h5,
		DASM_CMD_REF = 4'h6,
		DASM_CMD_DESEL = 4'h7
	} dasm_cmd_type;
	typedef enum logic [1:0]
	{
		DASM_IDLE = 2'h0,
		DASM_BUSY = 2'h1
	} dasm_state_type;
endpackage

/* File: common/dasm_if.sv */
`timescale 1ns/1ps
interface dasm_if;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic cke;
	logic bank_select_bit0;
	logic bank_select_bit1;
	logic [12:0] addr;
	logic [15:0] dq_ctl;
	logic [15:0] dq_dev;
	logic dq_dev_oe;
	logic lower_byte_strobe_ctl;
	logic upper_byte_strobe_ctl;
	logic strobe_ctl_oe;
	logic lower_byte_strobe_dev;
	logic upper_byte_strobe_dev;
	logic strobe_dev_oe;
	logic lower_byte_mask;
	logic upper_byte_mask;
	logic read_strobe_out;
	modport ctl (output cs_n, ras_n, cas_n, we_n, cke, bank_select_bit0, bank_select_bit1,
		addr, dq_ctl, lower_byte_strobe_ctl, upper_byte_strobe_ctl, strobe_ctl_oe,
		lower_byte_mask, upper_byte_mask,
		input dq_dev, dq_dev_oe, lower_byte_strobe_dev, upper_byte_strobe_dev,
		strobe_dev_oe, read_strobe_out);
	modport dev (input cs_n, ras_n, cas_n, we_n, cke, bank_select_bit0, bank_select_bit1,
		addr, dq_ctl, lower_byte_strobe_ctl, upper_byte_strobe_ctl, strobe_ctl_oe,
		lower_byte_mask, upper_byte_mask,
		output dq_dev, dq_dev_oe, lower_byte_strobe_dev, upper_byte_strobe_dev,
		strobe_dev_oe, read_strobe_out);
endinterface

/* File: hw/dasm_dev.sv */
`timescale 1ns/1ps
`include "dasm_map.svh"
// Contract
// - Two bank bits pick one of four
// - Address ten selects auto precharge
// - Row from thirteen low address lines
// - Column lines depend on data width
// - Page size is 1024 bytes always
// - Read strobe enabled by extended set one; the code enables it on byte-wide parts only
// - Read strobe on disables write masking
// - Read strobe toggles only during reads
// - Lower strobe low byte, upper high
// - Controller drives masks per byte lane
// - Commands decoded from control pins
// - Mode set uses bank bits selector
module dasm_dev
#(
	parameter logic [1:0] WIDTH_SEL = `DASM_W16,
	parameter int BURST_BEATS = 4
)
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Link
	dasm_if.dev link,
	// Decoded access
	output logic acc_valid_o,
	output dasm_pkg::dasm_cmd_type acc_cmd_o,
	output logic [1:0] acc_bank_o,
	output logic [12:0] acc_row_o,
	output logic [10:0] acc_col_o,
	output logic acc_autopre_o,
	output logic [15:0] acc_wdata_o,
	output logic [1:0] acc_wmask_o,
	output logic read_strobe_en_o,
	output logic [10:0] page_bytes_log2_o,
	// Read data from the array
	input wire logic [15:0] rdata_i
);
	import dasm_pkg::*;
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Link pins come from outside, so two flops before decode
	logic [19:0] s1_reg, s2_reg;
	logic [19:0] pins;
	logic [17:0] wd1_reg, wd2_reg;
	assign pins = {link.cs_n, link.ras_n, link.cas_n, link.we_n, link.cke,
		link.bank_select_bit1, link.bank_select_bit0, link.addr};
	always_ff @(posedge mclk_i)
	begin
		s1_reg <= pins;
		s2_reg <= s1_reg;
		wd1_reg <= {link.dq_ctl, link.lower_byte_mask, link.upper_byte_mask};
		wd2_reg <= wd1_reg;
	end
	logic cs_n, ras_n, cas_n, we_n, cke;
	logic [1:0] ba;
	logic [12:0] a;
	assign {cs_n, ras_n, cas_n, we_n, cke, ba, a} = s2_reg;
	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	dasm_cmd_type cmd;
	always_comb
	begin
		cmd = DASM_CMD_NOP;
		if (!cke || cs_n)
			cmd = DASM_CMD_DESEL;
		else
			case ({ras_n, cas_n, we_n})
				3'h0: cmd = DASM_CMD_MRS;
				3'h1: cmd = DASM_CMD_REF;
				3'h2: cmd = DASM_CMD_PRE;
				3'h3: cmd = DASM_CMD_ACT;
				3'h4: cmd = DASM_CMD_WR;
				3'h5: cmd = DASM_CMD_RD;
				default: cmd = DASM_CMD_NOP;
			endcase
	end
	// ----------------------------------------
	// Column extraction per width
	// ----------------------------------------
	logic [10:0] col;
	always_comb
	begin
		case (WIDTH_SEL)
			`DASM_W4: col = {a[`DASM_COL11_BIT], a[9:0]};
			`DASM_W8: col = {1'b0, a[9:0]};
			default: col = {2'h0, a[8:0]};
		endcase
	end
	// ----------------------------------------
	// Access state
	// ----------------------------------------
	dasm_state_type st_reg, st_next;
	logic [3:0] beat_reg, beat_next;
	logic rstrobe_en_reg, rstrobe_en_next;
	logic rstrobe_out_reg, rstrobe_out_next;
	logic valid_reg, valid_next;
	dasm_cmd_type cmd_reg, cmd_next;
	logic [1:0] bank_reg, bank_next;
	logic [12:0] row_reg, row_next;
	logic [10:0] col_reg, col_next;
	logic autopre_reg, autopre_next;
	logic [15:0] wdat_reg, wdat_next;
	logic [1:0] wmask_reg, wmask_next;
	logic rd_reg, rd_next;
	logic strobe_reg, strobe_next;
	logic [15:0] dq_reg, dq_next;
	always_comb
	begin
		st_next = st_reg;
		beat_next = beat_reg;
		rstrobe_en_next = rstrobe_en_reg;
		valid_next = 1'b0;
		cmd_next = cmd_reg;
		bank_next = bank_reg;
		row_next = row_reg;
		col_next = col_reg;
		autopre_next = autopre_reg;
		wdat_next = wd2_reg[17:2];
		// Lower mask covers the low byte, upper mask the high byte
		wmask_next = rstrobe_en_reg ? 2'h0 : wd2_reg[1:0];
		rd_next = 1'b0;
		strobe_next = 1'b0;
		dq_next = dq_reg;
		if (cmd == DASM_CMD_MRS && ba == `DASM_EMR1_SEL)
			rstrobe_en_next = (WIDTH_SEL == `DASM_W8) && a[`DASM_EMR_RSTROBE_BIT];
		if (cmd != DASM_CMD_NOP && cmd != DASM_CMD_DESEL)
		begin
			valid_next = 1'b1;
			cmd_next = cmd;
			bank_next = ba;
			if (cmd == DASM_CMD_ACT)
				row_next = a;
			if (cmd == DASM_CMD_RD || cmd == DASM_CMD_WR)
			begin
				col_next = col;
				autopre_next = a[`DASM_AUTOPRE_BIT];
			end
		end
		case (st_reg)
			DASM_IDLE:
				if (cmd == DASM_CMD_RD)
				begin
					st_next = DASM_BUSY;
					beat_next = 4'(BURST_BEATS - 1);
				end
			DASM_BUSY:
			begin
				rd_next = 1'b1;
				strobe_next = ~strobe_reg;
				dq_next = rdata_i;
				if (beat_reg == 4'h0)
					st_next = DASM_IDLE;
				else
					beat_next = beat_reg - 4'h1;
			end
			default: st_next = DASM_IDLE;
		endcase
		// Registered so the pin never glitches when the enable changes mid-burst
		rstrobe_out_next = strobe_next & rstrobe_en_next;
	end
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			st_reg <= DASM_IDLE;
			beat_reg <= 4'h0;
			rstrobe_en_reg <= 1'b0;
			rstrobe_out_reg <= 1'b0;
			valid_reg <= 1'b0;
			cmd_reg <= DASM_CMD_NOP;
			bank_reg <= 2'h0;
			row_reg <= 13'h0;
			col_reg <= 11'h0;
			autopre_reg <= 1'b0;
			wdat_reg <= 16'h0;
			wmask_reg <= 2'h0;
			rd_reg <= 1'b0;
			strobe_reg <= 1'b0;
			dq_reg <= 16'h0;
		end
		else
		begin
			st_reg <= st_next;
			beat_reg <= beat_next;
			rstrobe_en_reg <= rstrobe_en_next;
			rstrobe_out_reg <= rstrobe_out_next;
			valid_reg <= valid_next;
			cmd_reg <= cmd_next;
			bank_reg <= bank_next;
			row_reg <= row_next;
			col_reg <= col_next;
			autopre_reg <= autopre_next;
			wdat_reg <= wdat_next;
			wmask_reg <= wmask_next;
			rd_reg <= rd_next;
			strobe_reg <= strobe_next;
			dq_reg <= dq_next;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign acc_valid_o = valid_reg;
	assign acc_cmd_o = cmd_reg;
	assign acc_bank_o = bank_reg;
	assign acc_row_o = row_reg;
	assign acc_col_o = col_reg;
	assign acc_autopre_o = autopre_reg;
	assign acc_wdata_o = wdat_reg;
	assign acc_wmask_o = wmask_reg;
	assign read_strobe_en_o = rstrobe_en_reg;
	// Page byte count is the same for every width, so no width term
	assign page_bytes_log2_o = 11'(`DASM_PAGE_BYTES);
	assign link.dq_dev = dq_reg;
	assign link.dq_dev_oe = rd_reg;
	// Both strobes share one toggle; each times its own byte lane
	assign link.lower_byte_strobe_dev = strobe_reg;
	assign link.upper_byte_strobe_dev = strobe_reg;
	assign link.strobe_dev_oe = rd_reg;
	assign link.read_strobe_out = rstrobe_out_reg;
endmodule

/* File: hw/dasm_ctl.sv */
`timescale 1ns/1ps
`include "dasm_map.svh"
module dasm_ctl
#(
	parameter logic [1:0] WIDTH_SEL = `DASM_W16
)
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Request
	input wire logic req_i,
	input wire dasm_pkg::dasm_cmd_type req_cmd_i,
	input wire logic [25:0] req_addr_i,
	input wire logic req_autopre_i,
	input wire logic [1:0] req_bank_i,
	input wire logic [15:0] req_wdata_i,
	input wire logic [1:0] req_wmask_i,
	// Link
	dasm_if.ctl link
);
	import dasm_pkg::*;
	logic [3:0] ctl_reg, ctl_next;
	logic [1:0] ba_reg, ba_next;
	logic [12:0] a_reg, a_next;
	logic [15:0] d_reg, d_next;
	logic [1:0] m_reg, m_next;
	logic cke_reg, cke_next;
	logic [12:0] row;
	logic [10:0] col;
	logic [1:0] bank;
	// ----------------------------------------
	// Linear address split
	// ----------------------------------------
	always_comb
	begin
		case (WIDTH_SEL)
			`DASM_W4: {bank, row, col} = req_addr_i;
			// Byte-wide and word-wide parts pad the top column bits so bank and row stay aligned
			`DASM_W8: {bank, row, col} = {req_addr_i[24:10], 1'b0, req_addr_i[9:0]};
			default: {bank, row, col} = {req_addr_i[23:9], 2'h0, req_addr_i[8:0]};
		endcase
	end
	always_comb
	begin
		ctl_next = 4'hf;
		// Clock enable rises on the first edge out of reset
		cke_next = 1'b1;
		ba_next = ba_reg;
		a_next = a_reg;
		d_next = req_wdata_i;
		m_next = req_wmask_i;
		if (req_i)
		begin
			ba_next = bank;
			case (req_cmd_i)
				DASM_CMD_MRS:
				begin
					ctl_next = 4'h0;
					ba_next = req_bank_i;
					a_next = req_addr_i[12:0];
				end
				DASM_CMD_ACT:
				begin
					ctl_next = 4'h3;
					a_next = row;
				end
				DASM_CMD_RD, DASM_CMD_WR:
				begin
					ctl_next = (req_cmd_i == DASM_CMD_RD) ? 4'h5 : 4'h4;
					// Unused column lines stay low
					case (WIDTH_SEL)
						`DASM_W4: a_next = {1'b0, col[10], req_autopre_i, col[9:0]};
						`DASM_W8: a_next = {2'h0, req_autopre_i, col[9:0]};
						default: a_next = {2'h0, req_autopre_i, 1'b0, col[8:0]};
					endcase
				end
				DASM_CMD_PRE:
				begin
					ctl_next = 4'h2;
					a_next = {2'h0, req_autopre_i, 10'h0};
				end
				DASM_CMD_REF: ctl_next = 4'h1;
				default: ctl_next = 4'h7;
			endcase
		end
	end
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			ctl_reg <= 4'hf;
			ba_reg <= 2'h0;
			a_reg <= 13'h0;
			d_reg <= 16'h0;
			m_reg <= 2'h0;
			cke_reg <= 1'b0;
		end
		else
		begin
			ctl_reg <= ctl_next;
			ba_reg <= ba_next;
			a_reg <= a_next;
			d_reg <= d_next;
			m_reg <= m_next;
			cke_reg <= cke_next;
		end
	end
	assign link.cs_n = ctl_reg[3];
	assign {link.ras_n, link.cas_n, link.we_n} = ctl_reg[2:0];
	assign link.cke = cke_reg;
	assign link.bank_select_bit0 = ba_reg[0];
	assign link.bank_select_bit1 = ba_reg[1];
	assign link.addr = a_reg;
	assign link.dq_ctl = d_reg;
	assign link.lower_byte_mask = m_reg[1];
	assign link.upper_byte_mask = m_reg[0];
	assign link.lower_byte_strobe_ctl = 1'b0;
	assign link.upper_byte_strobe_ctl = 1'b0;
	assign link.strobe_ctl_oe = 1'b0;
endmodule

/* File: test/dasm_chk.sv */
`timescale 1ns/1ps
module dasm_chk
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Link
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic cke,
	input wire logic [12:0] addr,
	input wire logic dq_dev_oe,
	input wire logic lower_byte_strobe_dev,
	input wire logic upper_byte_strobe_dev,
	input wire logic strobe_dev_oe,
	input wire logic read_strobe_out
);
	// ---
	// Link rules, one clock domain
	// ---
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	wire col_cmd = !cs_n && ras_n && !cas_n;
	a_sel_cke: assert property (!cs_n |-> cke)
		else $error("select without clock enable");
	a_col_unused: assert property (col_cmd |-> addr[12:11] == 2'h0 && !addr[9])
		else $error("unused column line high");
	// A read seen while a burst runs may be ignored, so only idle reads count
	a_rd_burst: assert property (col_cmd && we_n && !dq_dev_oe |-> ##[4:7] dq_dev_oe)
		else $error("read without data burst");
	a_burst_len: assert property ($rose(dq_dev_oe) |-> dq_dev_oe[*4] ##1 !dq_dev_oe)
		else $error("burst length wrong");
	a_strobe_oe: assert property (strobe_dev_oe |-> dq_dev_oe)
		else $error("strobe driven outside burst");
	a_strobe_tog: assert property (dq_dev_oe && $past(dq_dev_oe)
		|-> lower_byte_strobe_dev != $past(lower_byte_strobe_dev))
		else $error("strobe did not toggle");
	a_lane_pair: assert property (strobe_dev_oe |-> upper_byte_strobe_dev == lower_byte_strobe_dev)
		else $error("lane strobes differ");
	a_no_rstrobe: assert property ($stable(read_strobe_out))
		else $error("read strobe moved on wide part");
	c_read: cover property (col_cmd && we_n);
	c_write: cover property (col_cmd && !we_n);
	c_burst: cover property ($fell(dq_dev_oe));
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`include "dasm_map.svh"
module tb_top;
	import dasm_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req_i = 1'b0;
	dasm_cmd_type req_cmd_i = DASM_CMD_NOP;
	logic [25:0] req_addr_i = 26'h0;
	logic req_autopre_i = 1'b0;
	logic [1:0] req_bank_i = 2'h0;
	logic [15:0] req_wdata_i = 16'h0;
	logic [1:0] req_wmask_i = 2'h0;
	logic [15:0] rdata_i = 16'ha5c3;
	logic acc_valid_o;
	logic acc_autopre_o;
	logic read_strobe_en_o;
	dasm_cmd_type acc_cmd_o;
	logic [1:0] acc_bank_o;
	logic [1:0] acc_wmask_o;
	logic [12:0] acc_row_o;
	logic [10:0] acc_col_o;
	logic [10:0] page_bytes_log2_o;
	logic [15:0] acc_wdata_o;
	logic [12:0] row;
	logic [8:0] col;
	int n_mismatch = 0;
	int tests_run = 0;
	int beats;
	int strobes;
	logic rstrobe_en_w8;
	logic [1:0] wmask_w8;
	dasm_if link();
	dasm_if link8();
	always #25 mclk_i = ~mclk_i;
	dasm_ctl u_dasm_ctl (.mclk_i, .rst_i, .req_i, .req_cmd_i, .req_addr_i, .req_autopre_i,
		.req_bank_i, .req_wdata_i, .req_wmask_i, .link(link.ctl));
	dasm_dev u_dasm_dev (.mclk_i, .rst_i, .link(link.dev), .acc_valid_o, .acc_cmd_o,
		.acc_bank_o, .acc_row_o, .acc_col_o, .acc_autopre_o, .acc_wdata_o, .acc_wmask_o,
		.read_strobe_en_o, .page_bytes_log2_o, .rdata_i);
	// Byte-wide pair shares the request inputs; it exercises the read strobe option
	dasm_ctl #(.WIDTH_SEL(`DASM_W8)) u_dasm_ctl_w8 (.mclk_i, .rst_i, .req_i, .req_cmd_i,
		.req_addr_i, .req_autopre_i, .req_bank_i, .req_wdata_i, .req_wmask_i,
		.link(link8.ctl));
	dasm_dev #(.WIDTH_SEL(`DASM_W8)) u_dasm_dev_w8 (.mclk_i, .rst_i, .link(link8.dev),
		.acc_valid_o(), .acc_cmd_o(), .acc_bank_o(), .acc_row_o(), .acc_col_o(),
		.acc_autopre_o(), .acc_wdata_o(), .acc_wmask_o(wmask_w8),
		.read_strobe_en_o(rstrobe_en_w8), .page_bytes_log2_o(), .rdata_i);
	dasm_chk u_dasm_chk (.mclk_i, .rst_i, .cs_n(link.cs_n), .ras_n(link.ras_n),
		.cas_n(link.cas_n), .we_n(link.we_n), .cke(link.cke), .addr(link.addr),
		.dq_dev_oe(link.dq_dev_oe), .lower_byte_strobe_dev(link.lower_byte_strobe_dev),
		.upper_byte_strobe_dev(link.upper_byte_strobe_dev),
		.strobe_dev_oe(link.strobe_dev_oe), .read_strobe_out(link.read_strobe_out));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One request cycle, then wait a bounded time for the decoded access
	task automatic issue(input dasm_cmd_type c, input logic [25:0] a, input logic ap,
		input logic [1:0] b, input logic [15:0] d);
		int k;
		@(posedge mclk_i);
		#1;
		req_i = 1'b1;
		req_cmd_i = c;
		req_addr_i = a;
		req_autopre_i = ap;
		req_bank_i = b;
		req_wdata_i = d;
		req_wmask_i = d[1:0];
		@(posedge mclk_i);
		#1;
		req_i = 1'b0;
		k = 0;
		while (acc_valid_o !== 1'b1 && k < 10)
		begin
			@(posedge mclk_i);
			#1;
			k++;
		end
		chk({15'h0, acc_valid_o}, 16'h1);
		chk({12'h0, acc_cmd_o}, {12'h0, c});
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge mclk_i);
		#1;
		rst_i = 1'b0;
		chk({5'h0, page_bytes_log2_o}, 16'h0400);
		for (int i = 0; i < 4; i++)
		begin
			// Address packing for the wide part: bank, 13 row bits, 9 column bits
			row = i[0] ? 13'h1fff : 13'h0aaa;
			col = i[1] ? 9'h1ff : 9'h0aa;
			issue(DASM_CMD_MRS, 26'h800, 1'b0, i[1:0], 16'h0);
			chk({14'h0, acc_bank_o}, {14'h0, i[1:0]});
			chk({15'h0, read_strobe_en_o}, 16'h0);
			chk({15'h0, rstrobe_en_w8}, {15'h0, i > 0});
			issue(DASM_CMD_ACT, {2'h0, i[1:0], row, 9'h0}, 1'b0, 2'h0, 16'h0);
			chk({14'h0, acc_bank_o}, {14'h0, i[1:0]});
			chk({3'h0, acc_row_o}, {3'h0, row});
			issue(DASM_CMD_RD, {2'h0, i[1:0], 13'h0, col}, i[0], 2'h0, 16'h0);
			chk({5'h0, acc_col_o}, {7'h0, col});
			chk({15'h0, acc_autopre_o}, {15'h0, i[0]});
			repeat (10) @(posedge mclk_i);
			issue(DASM_CMD_WR, {2'h0, i[1:0], 13'h0, col}, !i[0], 2'h0, 16'(16'h12ad + i));
			chk({15'h0, acc_autopre_o}, {15'h0, !i[0]});
			chk(acc_wdata_o, 16'(16'h12ad + i));
			chk({14'h0, acc_wmask_o}, {14'h0, 2'(16'h12ad + i)});
			chk({14'h0, wmask_w8}, (i > 0) ? 16'h0 : {14'h0, 2'(16'h12ad + i)});
		end
		issue(DASM_CMD_RD, 26'h0, 1'b0, 2'h0, 16'h0);
		beats = 0;
		strobes = 0;
		repeat (12)
		begin
			@(posedge mclk_i);
			#1;
			beats += int'(link.dq_dev_oe === 1'b1);
			strobes += int'(link8.read_strobe_out === 1'b1);
			if (link.dq_dev_oe === 1'b1)
				chk(link.dq_dev, 16'ha5c3);
		end
		chk(16'(beats), 16'h4);
		chk(16'(strobes), 16'h2);
		issue(DASM_CMD_PRE, 26'h0, 1'b0, 2'h0, 16'h0);
		issue(DASM_CMD_REF, 26'h0, 1'b0, 2'h0, 16'h0);
		@(posedge mclk_i);
		#1;
		req_i = 1'b1;
		req_cmd_i = DASM_CMD_NOP;
		@(posedge mclk_i);
		#1;
		req_i = 1'b0;
		beats = 0;
		repeat (8)
		begin
			@(posedge mclk_i);
			#1;
			beats += int'(acc_valid_o === 1'b1);
		end
		chk(16'(beats), 16'h0);
		end_of_test();
	end
	initial
	begin
		#100us;
		n_mismatch++;
		end_of_test();
	end
endmodule
